// >>> verilog/fan_drive_alarm_status_reset.sv
// Alarm coding, clearing, restart and register access of a fan motor drive
//
// Behaviour
// - Reference input reported as raw count, 10 V over 2^16 per count.
// - Input register 30 returns transducer raw count, same scaling.
// - Input register 31 returns absorbed power in watts.
// - Input register 32 returns input current in milliamperes.
// - Holding register 44 returns fan model code.
// - Input registers 0 and 1 return firmware version and drive model.
// - Blocking fault stops motor at once until reset.
// - Auto-restarting fault raises alarm, restarts motor after a delay.
// - Alarm visible in code registers, status light and digital output.
// - Codes 0/0 none, 1/0 memory, 2/0 short, 3/0 sync loss.
// - Code 4/1 input voltage out of range, only while stopped, auto.
// - Codes 4/32 bus overvoltage, 4/33 bus undervoltage, auto-restarting.
// - Code 4/34 input relay not closed, auto-restarting.
// - Codes 4/49, 4/50, 4/51 missing phase U, V, W, blocking.
// - Codes 4/52 starting current, 4/113 overtemperature, auto-restarting.
// - Code 4/255 communication loss, blocking.
// - Output function 1: output low normally, high while alarm active.
// - Analog input types 1,4,7,10 clear alarms when command is zero.
// - Fixed input types 2,6,9,12 clear alarms when four set registers zero.
// - Temporary mode clears only by writing 1 to register 0.
// - Writing 1 to holding register 0 clears alarms in every mode.
// - Nonzero communication timeout expiring stops fan with alarm until reset.
`timescale 1ns/1ps
`include "fan_alarm_cfg.svh"

module fan_drive_alarm_status_reset
   import fan_alarm_pkg::*;
#(
   parameter logic [31:0] SECOND_CYCLES    = `SECOND_CYCLES,
   parameter logic [15:0] RESTART_SECONDS  = `RESTART_DELAY_S,
   parameter logic [15:0] FIRMWARE_VERSION = 16'h0001, // Arbitrary value
   parameter logic [15:0] DRIVE_MODEL_ID   = 16'h0A5A, // Arbitrary value
   parameter logic [15:0] FAN_MODEL_CODE   = 16'h0001  // Arbitrary value
)(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   // Register access, one request per clkEn cycle with accValid high
   input  wire logic        accValid,
   input  wire logic        accWrite,
   input  wire logic        accHolding,
   input  wire logic [15:0] accAddr,
   input  wire logic [15:0] accWdata,
   output logic             rspValid,
   output logic [15:0]      rspData,
   output logic             rspError,
   // Measurements
   input  wire logic [15:0] referenceRaw,
   input  wire logic [15:0] transducerRaw,
   input  wire logic [15:0] powerWatts,
   input  wire logic [15:0] currentMilliamps,
   // Fault detectors, each a level or pulse
   input  wire logic        faultMemory,
   input  wire logic        faultShort,
   input  wire logic        faultSync,
   input  wire logic        faultInputVolt,
   input  wire logic        faultBusOver,
   input  wire logic        faultBusUnder,
   input  wire logic        faultRelay,
   input  wire logic [2:0]  faultPhase,
   input  wire logic        faultStartCurrent,
   input  wire logic        faultOverTemp,
   // Drive side
   output logic             motorRun,
   output logic             alarmOut,
   output logic             statusLed
);

   alarm_state_e     state;
   logic [15:0]      alarmMain;
   logic [15:0]      alarmSub;
   logic [15:0]      generalReset;
   logic [15:0]      outputFunction;
   logic [15:0]      inputType;
   logic [15:0]      commTimeout;
   logic [15:0]      tempSpeed;
   logic [15:0]      fixedSet [4];
   logic [31:0]      prescaler;
   logic             secondTick;
   logic [15:0]      idleSeconds;
   logic [15:0]      restartSeconds;
   logic             commExpired;
   logic [12:0]      faultVec;
   fault_s           newFault;
   logic             clearReq;
   logic             resetWrite;
   logic             fixedWrite;
   logic             fixedAllZero;
   logic             holdWrite;

   // Input type decoding for the reset actions
   function automatic logic isAnalogType(input logic [15:0] t);
      return (t == 16'h0001) || (t == 16'h0004) || (t == 16'h0007) || (t == 16'h000A);
   endfunction

   function automatic logic isFixedType(input logic [15:0] t);
      return (t == 16'h0002) || (t == 16'h0006) || (t == 16'h0009) || (t == 16'h000C);
   endfunction

   function automatic int fixedIndex(input logic [15:0] a);
      case (a)
         `HR_FIXED_SET_A: return 0;
         `HR_FIXED_SET_B: return 1;
         `HR_FIXED_SET_C: return 2;
         `HR_FIXED_SET_D: return 3;
         default:         return -1;
      endcase
   endfunction

   // Fault code table; lower index has priority, blocking ones first
   function automatic fault_s faultCode(input int idx);
      fault_s f;
      f = '{valid: 1'b1, blocking: 1'b0, mainCode: `MAIN_GROUP4, subCode: `SUB_NONE};
      case (idx)
         F_MEMORY:     begin f.mainCode = `MAIN_MEMORY; f.blocking = 1'b1; end
         F_SHORT:      begin f.mainCode = `MAIN_SHORT;  f.blocking = 1'b1; end
         F_PHASE_U:    begin f.subCode = `SUB_PHASE_U; f.blocking = 1'b1; end
         F_PHASE_V:    begin f.subCode = `SUB_PHASE_V; f.blocking = 1'b1; end
         F_PHASE_W:    begin f.subCode = `SUB_PHASE_W; f.blocking = 1'b1; end
         F_COMM:       begin f.subCode = `SUB_COMM_LOSS; f.blocking = 1'b1; end
         F_SYNC:       f.mainCode = `MAIN_SYNC;
         F_INPUT_VOLT: f.subCode = `SUB_INPUT_VOLT;
         F_BUS_OVER:   f.subCode = `SUB_BUS_OVER;
         F_BUS_UNDER:  f.subCode = `SUB_BUS_UNDER;
         F_RELAY:      f.subCode = `SUB_RELAY_OPEN;
         F_START_CUR:  f.subCode = `SUB_START_CURRENT;
         default:      f.subCode = `SUB_OVER_TEMP;
      endcase
      return f;
   endfunction

   assign holdWrite  = clkEn && accValid && accWrite && accHolding;
   assign resetWrite = holdWrite && (accAddr == `HR_GENERAL_RESET) && (accWdata == `GENERAL_RESET_CMD);
   assign fixedWrite = holdWrite && (fixedIndex(accAddr) >= 0);

   // Checks the set values after the pending write lands
   always_comb begin
      fixedAllZero = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (fixedWrite && (fixedIndex(accAddr) == i)) begin
            if (accWdata != 16'h0000) fixedAllZero = 1'b0;
         end else if (fixedSet[i] != 16'h0000) begin
            fixedAllZero = 1'b0;
         end
      end
   end

   always_comb begin
      clearReq = resetWrite;
      if (isAnalogType(inputType) && (referenceRaw == 16'h0000))
         clearReq = 1'b1;
      if (isFixedType(inputType) && fixedWrite && fixedAllZero)
         clearReq = 1'b1;
   end

   assign faultVec = {faultOverTemp, faultStartCurrent, faultRelay, faultBusUnder, faultBusOver,
                      faultInputVolt && !motorRun,
                      faultSync, commExpired, faultPhase[2], faultPhase[1], faultPhase[0],
                      faultShort, faultMemory};

   always_comb begin
      newFault = '{valid: 1'b0, blocking: 1'b0, mainCode: `MAIN_NONE, subCode: `SUB_NONE};
      for (int i = 12; i >= 0; i--) begin
         if (faultVec[i]) newFault = faultCode(i);
      end
   end

   // One-second tick shared by timeout and restart delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prescaler  <= 32'h00000000;
         secondTick <= 1'b0;
      end else if (clkEn) begin
         secondTick <= (prescaler == SECOND_CYCLES - 32'h00000001);
         if (prescaler == SECOND_CYCLES - 32'h00000001) prescaler <= 32'h00000000;
         else prescaler <= prescaler + 32'h00000001;
      end
   end

   // Traffic watchdog; any access restarts it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         idleSeconds <= 16'h0000;
         commExpired <= 1'b0;
      end else if (clkEn) begin
         commExpired <= 1'b0;
         if (accValid || commTimeout == 16'h0000) begin
            idleSeconds <= 16'h0000;
         end else if (secondTick) begin
            if (idleSeconds + 16'h0001 >= commTimeout) begin
               commExpired <= 1'b1;
               idleSeconds <= 16'h0000;
            end else begin
               idleSeconds <= idleSeconds + 16'h0001;
            end
         end
      end
   end

   // Alarm state; a blocking fault in the clear cycle wins over the clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state          <= ST_RUN;
         alarmMain      <= `MAIN_NONE;
         alarmSub       <= `SUB_NONE;
         restartSeconds <= 16'h0000;
      end else if (clkEn) begin
         case (state)
            ST_RUN: begin
               if (newFault.valid) begin
                  alarmMain      <= newFault.mainCode;
                  alarmSub       <= newFault.subCode;
                  restartSeconds <= 16'h0000;
                  state          <= newFault.blocking ? ST_BLOCKED : ST_RESTART;
               end
            end
            ST_RESTART: begin
               if (newFault.valid && newFault.blocking) begin
                  alarmMain <= newFault.mainCode;
                  alarmSub  <= newFault.subCode;
                  state     <= ST_BLOCKED;
               end else if (clearReq ||
                            (secondTick && restartSeconds + 16'h0001 >= RESTART_SECONDS)) begin
                  alarmMain <= `MAIN_NONE;
                  alarmSub  <= `SUB_NONE;
                  state     <= ST_RUN;
               end else if (secondTick) begin
                  restartSeconds <= restartSeconds + 16'h0001;
               end
            end
            ST_BLOCKED: begin
               // Only a reset action frees a blocking fault
               if (clearReq && !(newFault.valid && newFault.blocking)) begin
                  alarmMain <= `MAIN_NONE;
                  alarmSub  <= `SUB_NONE;
                  state     <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   // Outputs follow state one cycle later, straight from flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         motorRun  <= 1'b1;
         alarmOut  <= 1'b0;
         statusLed <= 1'b0;
      end else if (clkEn) begin
         motorRun  <= (state == ST_RUN);
         statusLed <= (state != ST_RUN);
         // Other output functions are produced elsewhere; this output stays low then
         alarmOut  <= (outputFunction == `OUTFUNC_ALARM) && (state != ST_RUN);
      end
   end

   // Holding register writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         generalReset   <= 16'h0000;
         outputFunction <= `OUTFUNC_RESET;
         inputType      <= `INPUT_TYPE_RESET;
         commTimeout    <= 16'h0000;
         tempSpeed      <= 16'h0000;
         for (int i = 0; i < 4; i++) fixedSet[i] <= 16'h0000;
      end else if (holdWrite) begin
         case (accAddr)
            `HR_GENERAL_RESET:   generalReset   <= accWdata;
            `HR_OUTPUT_FUNCTION: outputFunction <= accWdata;
            `HR_INPUT_TYPE:      inputType      <= accWdata;
            `HR_COMM_TIMEOUT:    commTimeout    <= accWdata;
            `HR_TEMP_SPEED:      tempSpeed      <= accWdata;
            default: begin
               if (fixedWrite) fixedSet[fixedIndex(accAddr)] <= accWdata;
            end
         endcase
      end
   end

   // Register reads and write answers, one cycle after the request
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rspValid <= 1'b0;
         rspData  <= 16'h0000;
         rspError <= 1'b0;
      end else if (clkEn) begin
         rspValid <= accValid;
         rspData  <= 16'h0000;
         rspError <= 1'b0;
         if (accValid && accHolding) begin
            case (accAddr)
               `HR_GENERAL_RESET:   rspData <= generalReset;
               `HR_FIXED_SET_A:     rspData <= fixedSet[0];
               `HR_FIXED_SET_B:     rspData <= fixedSet[1];
               `HR_FIXED_SET_C:     rspData <= fixedSet[2];
               `HR_FIXED_SET_D:     rspData <= fixedSet[3];
               `HR_OUTPUT_FUNCTION: rspData <= outputFunction;
               `HR_INPUT_TYPE:      rspData <= inputType;
               `HR_COMM_TIMEOUT:    rspData <= commTimeout;
               `HR_TEMP_SPEED:      rspData <= tempSpeed;
               `HR_FAN_MODEL_CODE: begin
                  rspData  <= FAN_MODEL_CODE;
                  rspError <= accWrite;
               end
               default: rspError <= 1'b1;
            endcase
            if (accWrite) rspData <= 16'h0000;
         end else if (accValid) begin
            // Input registers are read only
            rspError <= accWrite;
            case (accAddr)
               `IR_FIRMWARE_VERSION: rspData <= FIRMWARE_VERSION;
               `IR_DRIVE_MODEL_ID:   rspData <= DRIVE_MODEL_ID;
               `IR_ALARM_MAIN:       rspData <= alarmMain;
               `IR_ALARM_SUB:        rspData <= alarmSub;
               `IR_REFERENCE_LEVEL:  rspData <= referenceRaw;
               `IR_TRANSDUCER_LEVEL: rspData <= transducerRaw;
               `IR_ABSORBED_POWER:   rspData <= powerWatts;
               `IR_INPUT_CURRENT:    rspData <= currentMilliamps;
               default:              rspError <= 1'b1;
            endcase
            if (accWrite) rspData <= 16'h0000;
         end
      end
   end

endmodule

// >>> include/fan_alarm_cfg.svh
// Register offsets, codes and timing constants of the fan drive alarm block
`ifndef FAN_ALARM_CFG_SVH
`define FAN_ALARM_CFG_SVH

// Holding register space
`define HR_GENERAL_RESET     16'h0000
`define HR_FIXED_SET_A       16'h0015
`define HR_FIXED_SET_C       16'h001E
`define HR_FIXED_SET_B       16'h0027
`define HR_FAN_MODEL_CODE    16'h002C
`define HR_OUTPUT_FUNCTION   16'h002E
`define HR_FIXED_SET_D       16'h0032
`define HR_COMM_TIMEOUT      16'h0038
`define HR_INPUT_TYPE        16'h0040
`define HR_TEMP_SPEED        16'h0042

// Input register space
`define IR_FIRMWARE_VERSION  16'h0000
`define IR_DRIVE_MODEL_ID    16'h0001
`define IR_ALARM_MAIN        16'h000A
`define IR_ALARM_SUB         16'h0011
`define IR_REFERENCE_LEVEL   16'h001D
`define IR_TRANSDUCER_LEVEL  16'h001E
`define IR_ABSORBED_POWER    16'h001F
`define IR_INPUT_CURRENT     16'h0020

// Command codes and reset values
`define GENERAL_RESET_CMD    16'h0001
`define OUTFUNC_ALARM        16'h0001
`define OUTFUNC_RESET        16'h0000
`define INPUT_TYPE_RESET     16'h0001

// Alarm main and sub codes
`define MAIN_NONE            16'h0000
`define MAIN_MEMORY          16'h0001
`define MAIN_SHORT           16'h0002
`define MAIN_SYNC            16'h0003
`define MAIN_GROUP4          16'h0004
`define SUB_NONE             16'h0000
`define SUB_INPUT_VOLT       16'h0001
`define SUB_BUS_OVER         16'h0020
`define SUB_BUS_UNDER        16'h0021
`define SUB_RELAY_OPEN       16'h0022
`define SUB_PHASE_U          16'h0031
`define SUB_PHASE_V          16'h0032
`define SUB_PHASE_W          16'h0033
`define SUB_START_CURRENT    16'h0034
`define SUB_OVER_TEMP        16'h0071
`define SUB_COMM_LOSS        16'h00FF

// Timing
`define CLK_FREQ_HZ          32'h00989680
`define SECOND_TIME_S        32'h00000001
`define SECOND_CYCLES        (`CLK_FREQ_HZ * `SECOND_TIME_S)
`define RESTART_DELAY_S      16'h000A

`endif

// >>> include/fan_alarm_pkg.sv
// Types shared by the fan drive alarm block
package fan_alarm_pkg;

   typedef enum logic [2:0] {
      ST_RUN     = 3'b001,
      ST_BLOCKED = 3'b010,
      ST_RESTART = 3'b100
   } alarm_state_e;

   typedef struct packed {
      logic        valid;
      logic        blocking;
      logic [15:0] mainCode;
      logic [15:0] subCode;
   } fault_s;

   // Fault source index, lowest index wins
   typedef enum logic [3:0] {
      F_MEMORY, F_SHORT, F_PHASE_U, F_PHASE_V, F_PHASE_W, F_COMM,
      F_SYNC, F_INPUT_VOLT, F_BUS_OVER, F_BUS_UNDER, F_RELAY, F_START_CUR, F_OVER_TEMP
   } fault_src_t;

endpackage

// >>> test/fan_alarm_checker.sv
// Port-level assertions for the fan drive alarm block
`timescale 1ns/1ps
`include "fan_alarm_cfg.svh"
module fan_alarm_checker (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        clkEn,
   input wire logic        accValid,
   input wire logic        accWrite,
   input wire logic        accHolding,
   input wire logic [15:0] accAddr,
   input wire logic [15:0] rspData,
   input wire logic        rspValid,
   input wire logic        rspError,
   input wire logic [15:0] transducerRaw,
   input wire logic [15:0] powerWatts,
   input wire logic [15:0] currentMilliamps,
   input wire logic        faultMemory,
   input wire logic        motorRun,
   input wire logic        alarmOut,
   input wire logic        statusLed
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic req;
   logic irRd;
   assign req  = clkEn && accValid;
   assign irRd = req && !accWrite && !accHolding;

   chk_rsp_next: assert property (req |=> rspValid)
      else $error("request without answer");
   chk_rsp_cause: assert property (rspValid |-> $past(req))
      else $error("answer without request");
   chk_wr_zero: assert property (req && accWrite |=> rspData == 16'h0000)
      else $error("write answer carries data");
   chk_ir_write_err: assert property (req && accWrite && !accHolding |=> rspError)
      else $error("input space write accepted");
   chk_rd_transducer: assert property (irRd && accAddr == `IR_TRANSDUCER_LEVEL |=>
      rspData == $past(transducerRaw) && !rspError)
      else $error("transducer read wrong");
   chk_rd_power: assert property (irRd && accAddr == `IR_ABSORBED_POWER |=>
      rspData == $past(powerWatts) && !rspError)
      else $error("power read wrong");
   chk_rd_current: assert property (irRd && accAddr == `IR_INPUT_CURRENT |=>
      rspData == $past(currentMilliamps) && !rspError)
      else $error("current read wrong");
   chk_memory_stop: assert property (clkEn && faultMemory |-> ##2 (!motorRun && statusLed))
      else $error("memory fault did not stop motor");
   chk_out_alarm: assert property (alarmOut |-> statusLed)
      else $error("alarm output without alarm");

   cover property ($fell(motorRun));
   cover property ($rose(motorRun));
   cover property (rspValid && rspError);
endmodule

bind fan_drive_alarm_status_reset fan_alarm_checker chk_u (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
   .accValid(accValid), .accWrite(accWrite), .accHolding(accHolding), .accAddr(accAddr), .rspData(rspData),
   .rspValid(rspValid), .rspError(rspError), .transducerRaw(transducerRaw), .powerWatts(powerWatts),
   .currentMilliamps(currentMilliamps), .faultMemory(faultMemory), .motorRun(motorRun),
   .alarmOut(alarmOut), .statusLed(statusLed));

// >>> test/modbus_master_model.sv
// Register master model issuing one request per call
`timescale 1ns/1ps
module modbus_master_model (
   input  wire logic        core_clk,
   output logic             accValid,
   output logic             accWrite,
   output logic             accHolding,
   output logic [15:0]      accAddr,
   output logic [15:0]      accWdata,
   input  wire logic        rspValid,
   input  wire logic [15:0] rspData,
   input  wire logic        rspError
);
   logic        gotRsp;
   logic [15:0] rdData;
   logic        rdErr;
   initial begin
      accValid = 1'b0;
      accWrite = 1'b0;
      accHolding = 1'b0;
      accAddr = 16'h0000;
      accWdata = 16'h0000;
   end
   // Reads and writes go to holding space when h is set, to input space otherwise
   task automatic xfer(input logic w, input logic h, input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      accValid <= 1'b1;
      accWrite <= w;
      accHolding <= h;
      accAddr <= a;
      accWdata <= d;
      @(posedge core_clk);
      accValid <= 1'b0;
      // Released lines must not keep showing the old value
      accAddr <= ~a;
      accWdata <= ~d;
      // Answer stands one cycle only, so take it just after its launch edge
      #1;
      gotRsp = rspValid;
      rdData = rspData;
      rdErr = rspError;
   endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the fan drive alarm block
`timescale 1ns/1ps
`include "fan_alarm_cfg.svh"
module tb_top;
   import fan_alarm_pkg::*;
   localparam logic [15:0] FW = 16'h0102; // Arbitrary value
   localparam logic [15:0] MODEL = 16'h0B0C; // Arbitrary value
   localparam logic [15:0] FAN = 16'h0003; // Arbitrary value
   localparam logic [15:0] MAINS [12] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004, 16'h0004, 16'h0003,
      16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004, 16'h0004};
   localparam logic [15:0] SUBS [12] = '{16'h0000, 16'h0000, 16'h0031, 16'h0032, 16'h0033, 16'h0000,
      16'h0001, 16'h0020, 16'h0021, 16'h0022, 16'h0034, 16'h0071};
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] flt = 12'h000;
   logic [15:0] refLvl = 16'h1234;
   logic [15:0] tdRaw = 16'hFEDC;
   logic        clkEnable = 1'b1;
   logic        accValid, accWrite, accHolding, rspValid, rspError, motorRun, alarmOut, statusLed;
   logic [15:0] accAddr, accWdata, rspData;
   int          numErrors = 0;
   int          nCompared = 0;
   logic [15:0] tp [4] = '{16'h0001, 16'h0004, 16'h0007, 16'h000A};
   logic [15:0] tf [4] = '{16'h0002, 16'h0006, 16'h0009, 16'h000C};

   always #50 core_clk = ~core_clk;

   modbus_master_model mst_u (.core_clk(core_clk), .accValid(accValid), .accWrite(accWrite),
      .accHolding(accHolding), .accAddr(accAddr), .accWdata(accWdata), .rspValid(rspValid),
      .rspData(rspData), .rspError(rspError));

   fan_drive_alarm_status_reset #(.SECOND_CYCLES(32'h00000014), .RESTART_SECONDS(16'h0002),
      .FIRMWARE_VERSION(FW), .DRIVE_MODEL_ID(MODEL), .FAN_MODEL_CODE(FAN)) dut_u (
      .core_clk(core_clk), .rst(rst), .clkEn(clkEnable), .accValid(accValid), .accWrite(accWrite),
      .accHolding(accHolding), .accAddr(accAddr), .accWdata(accWdata), .rspValid(rspValid),
      .rspData(rspData), .rspError(rspError), .referenceRaw(refLvl), .transducerRaw(tdRaw),
      .powerWatts(16'h0437), .currentMilliamps(16'h1A2B), .faultMemory(flt[0]), .faultShort(flt[1]),
      .faultPhase(flt[4:2]), .faultSync(flt[5]), .faultInputVolt(flt[6]), .faultBusOver(flt[7]),
      .faultBusUnder(flt[8]), .faultRelay(flt[9]), .faultStartCurrent(flt[10]),
      .faultOverTemp(flt[11]), .motorRun(motorRun), .alarmOut(alarmOut), .statusLed(statusLed));

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic h, input logic [15:0] a, input logic [15:0] e, input logic er);
      mst_u.xfer(1'b0, h, a, 16'h0000);
      check1(mst_u.gotRsp, 1'b1);
      check16(mst_u.rdData, e);
      check1(mst_u.rdErr, er);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      mst_u.xfer(1'b1, 1'b1, a, d);
      check1(mst_u.gotRsp, 1'b1);
      check1(mst_u.rdErr, 1'b0);
   endtask
   task automatic state(input logic [15:0] m, input logic [15:0] s, input logic run, input logic out);
      check1(motorRun, run);
      check1(statusLed, m != 16'h0000);
      check1(alarmOut, out);
      rd(1'b0, `IR_ALARM_MAIN, m, 1'b0);
      rd(1'b0, `IR_ALARM_SUB, s, 1'b0);
   endtask
   task automatic hit(input int i);
      @(posedge core_clk);
      flt[i] <= 1'b1;
      @(posedge core_clk);
      flt[i] <= 1'b0;
      waitc(2);
   endtask
   task automatic clr();
      wr(`HR_GENERAL_RESET, `GENERAL_RESET_CMD);
      waitc(1);
      state(16'h0000, 16'h0000, 1'b1, 1'b0);
   endtask
   task automatic giveVerdict();
      $display("compared %0d mismatches %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (6000) @(posedge core_clk);
      numErrors++;
      $display("[ERR] %0t watchdog expired", $time);
      giveVerdict();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      waitc(1);
      state(16'h0000, 16'h0000, 1'b1, 1'b0);
      rd(1'b0, `IR_FIRMWARE_VERSION, FW, 1'b0);
      rd(1'b0, `IR_DRIVE_MODEL_ID, MODEL, 1'b0);
      rd(1'b0, `IR_REFERENCE_LEVEL, 16'h1234, 1'b0);
      rd(1'b0, `IR_TRANSDUCER_LEVEL, 16'hFEDC, 1'b0);
      rd(1'b0, `IR_ABSORBED_POWER, 16'h0437, 1'b0);
      rd(1'b0, `IR_INPUT_CURRENT, 16'h1A2B, 1'b0);
      rd(1'b0, 16'h0021, 16'h0000, 1'b1);
      mst_u.xfer(1'b1, 1'b1, `HR_FAN_MODEL_CODE, 16'h0009);
      check1(mst_u.rdErr, 1'b1);
      rd(1'b1, `HR_FAN_MODEL_CODE, FAN, 1'b0);
      @(posedge core_clk);
      tdRaw <= 16'h0123;
      rd(1'b0, `IR_TRANSDUCER_LEVEL, 16'h0123, 1'b0);
      // Fault pulse while frozen must leave no trace
      @(posedge core_clk);
      clkEnable <= 1'b0;
      hit(1);
      @(posedge core_clk);
      clkEnable <= 1'b1;
      waitc(1);
      state(16'h0000, 16'h0000, 1'b1, 1'b0);
      $display("test registers done");
      hit(1);
      state(16'h0002, 16'h0000, 1'b0, 1'b0);
      clr();
      wr(`HR_OUTPUT_FUNCTION, `OUTFUNC_ALARM);
      rd(1'b1, `HR_OUTPUT_FUNCTION, `OUTFUNC_ALARM, 1'b0);
      hit(6);
      state(16'h0000, 16'h0000, 1'b1, 1'b0);
      for (int k = 0; k < 12; k++) begin
         if (k != 6) begin
            hit(k);
            state(MAINS[k], SUBS[k], 1'b0, 1'b1);
            waitc(60);
            if (k < 5) begin
               check1(motorRun, 1'b0);
               clr();
            end else begin
               state(16'h0000, 16'h0000, 1'b1, 1'b0);
            end
         end
      end
      $display("test fault codes done");
      wr(`HR_COMM_TIMEOUT, 16'h0001);
      waitc(60);
      state(16'h0004, 16'h00FF, 1'b0, 1'b1);
      wr(`HR_COMM_TIMEOUT, 16'h0000);
      clr();
      $display("test comm timeout done");
      for (int k = 0; k < 4; k++) begin
         wr(`HR_INPUT_TYPE, tp[k]);
         hit(1);
         @(posedge core_clk);
         refLvl <= 16'h0000;
         waitc(3);
         state(16'h0000, 16'h0000, 1'b1, 1'b0);
         @(posedge core_clk);
         refLvl <= 16'h1234;
         wr(`HR_INPUT_TYPE, tf[k]);
         hit(1);
         wr(`HR_FIXED_SET_A, 16'h0000);
         wr(`HR_FIXED_SET_B, 16'h0000);
         wr(`HR_FIXED_SET_C, 16'h0000);
         wr(`HR_FIXED_SET_D, 16'h0000);
         waitc(1);
         state(16'h0000, 16'h0000, 1'b1, 1'b0);
      end
      $display("test mode clears done");
      wr(`HR_INPUT_TYPE, 16'h0003);
      hit(1);
      wr(`HR_TEMP_SPEED, 16'h0000);
      waitc(1);
      state(16'h0002, 16'h0000, 1'b0, 1'b1);
      clr();
      $display("test temporary mode done");
      giveVerdict();
   end
endmodule
